// file: logic/cij_unit.sv
`include "cij_cfg.svh"
module cij_unit #(
  parameter int W      = 64,
  parameter bit HAS_BASE = 1'b1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             instr_valid,
  input  wire logic [31:0]      instr,
  input  wire logic [W-1:0]     instr_pc,
  input  wire logic [W-1:0]     reg_a,
  input  wire logic [W-1:0]     reg_b,
  input  wire logic             sole_compressed_set_flag,
  input  wire logic             hazards_pending,
  input  wire logic             load_valid,
  input  wire logic [7:0]       load_byte,
  output logic                  redirect,
  output logic [W-1:0]          redirect_pc,
  output logic                  instruction_set_mode_bit,
  output logic                  squash,
  output logic                  stall,
  output logic                  target_fault,
  output logic                  clear_exec_hazard,
  output logic                  clear_instr_hazard,
  output logic                  wb_en,
  output logic [4:0]            wb_reg,
  output logic [W-1:0]          wb_data,
  output logic                  load_req,
  output logic [W-1:0]          load_addr
);
  import cij_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic [5:0]   major   = instr[31:26];
  wire logic [4:0]   sub     = instr[25:21];
  wire logic [4:0]   rt_f    = instr[20:16];
  wire logic [4:0]   rs_f    = instr[25:21];
  wire logic [W-1:0] off_sx  = {{(W-16){instr[15]}}, instr[15:0]};
  wire logic is_jial = (major == `CIJ_OP_GROUP_A) && (sub == `CIJ_SUB_INDEXED);
  wire logic is_jic  = (major == `CIJ_OP_GROUP_B) && (sub == `CIJ_SUB_INDEXED);
  // register jump shares this encoding with rt zero
  wire logic is_bar  = (major == `CIJ_POOL_MAJOR) && (instr[15:6] == `CIJ_BAR_MINOR)
                       && (instr[5:0] == `CIJ_POOL_MINOR);
  wire logic is_ehb  = (instr == `CIJ_EHB_WORD);
  wire logic is_ldb  = (major == 6'h07);
  cij_kind_t kind;
  assign kind = is_jial ? CIJ_K_JIAL : is_jic ? CIJ_K_JIC : is_bar ? CIJ_K_BAR :
                is_ehb ? CIJ_K_EHB : is_ldb ? CIJ_K_LDB : CIJ_K_NONE;

  // ****************************************************************
  // Target formation
  // ****************************************************************
  function automatic logic [W-1:0] add_w(input logic [W-1:0] a, input logic [W-1:0] b);
    add_w = a + b;
  endfunction
  // unshifted offset added bit for bit
  wire logic [W-1:0] idx_tgt = add_w(reg_a, off_sx);
  wire logic [W-1:0] tgt     = (kind == CIJ_K_BAR) ? reg_b : idx_tgt;
  wire logic [W-1:0] pc_tgt  = sole_compressed_set_flag ? tgt : {tgt[W-1:1], 1'b0};
  wire logic         mode_n  = sole_compressed_set_flag ? instruction_set_mode_bit : tgt[0];
  wire logic fault_n = !sole_compressed_set_flag && !tgt[0] && (!HAS_BASE || tgt[1]);
  // link is jump address plus 4
  wire logic [W-1:0] link    = add_w(instr_pc, W'(`CIJ_LINK_INC));
  wire logic is_jump = instr_valid && (kind == CIJ_K_JIC || kind == CIJ_K_JIAL
                                       || kind == CIJ_K_BAR);

  // ****************************************************************
  // Control
  // ****************************************************************
  cij_state_t state_q, state_d;
  logic [W-1:0] pend_pc_q;
  logic         pend_mode_q, pend_fault_q;
  logic [4:0]   load_rt_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      CIJ_IDLE:  if (is_jump && kind == CIJ_K_BAR) state_d = CIJ_DRAIN;
      CIJ_DRAIN: if (!hazards_pending) state_d = CIJ_GO;
      CIJ_GO:    state_d = CIJ_IDLE;
      default:   state_d = CIJ_IDLE;
    endcase
  end
  wire logic accept = (state_q == CIJ_IDLE);
  // next instruction accepted right after a non-barrier jump
  wire logic fire_now = accept && is_jump && kind != CIJ_K_BAR;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q                  <= CIJ_IDLE;
      pend_pc_q                <= '0;
      pend_mode_q              <= 1'b1;
      pend_fault_q             <= 1'b0;
      load_rt_q                <= 5'h00;
      redirect                 <= 1'b0;
      redirect_pc              <= '0;
      instruction_set_mode_bit <= 1'b1;
      squash                   <= 1'b0;
      stall                    <= 1'b0;
      target_fault             <= 1'b0;
      clear_exec_hazard        <= 1'b0;
      clear_instr_hazard       <= 1'b0;
      wb_en                    <= 1'b0;
      wb_reg                   <= 5'h00;
      wb_data                  <= '0;
      load_req                 <= 1'b0;
      load_addr                <= '0;
    end else begin
      state_q <= state_d;
      if (accept && is_jump) begin
        pend_pc_q    <= pc_tgt;
        pend_mode_q  <= mode_n;
        pend_fault_q <= fault_n;
      end
      // redirect one cycle after a non-barrier jump, or one cycle after CIJ_GO for a barrier
      redirect <= fire_now || (state_q == CIJ_GO);
      redirect_pc <= fire_now ? pc_tgt : pend_pc_q;
      if (fire_now)
        instruction_set_mode_bit <= mode_n;
      else if (state_q == CIJ_GO)
        instruction_set_mode_bit <= pend_mode_q;
      // fault reported with the target fetch
      target_fault <= fire_now ? fault_n : (state_q == CIJ_GO) && pend_fault_q;
      squash <= (accept && is_jump) || (state_q == CIJ_DRAIN);
      stall  <= (state_d == CIJ_DRAIN);
      clear_exec_hazard  <= (accept && instr_valid && kind == CIJ_K_EHB)
                            || (state_q == CIJ_GO);
      clear_instr_hazard <= (state_q == CIJ_GO);
      // barrier link into rt; indexed link into 31
      wb_en   <= (accept && instr_valid && (kind == CIJ_K_JIAL
                  || (kind == CIJ_K_BAR && rt_f != 5'h00))) || load_valid;
      wb_reg  <= load_valid ? load_rt_q
               : (accept && instr_valid && kind == CIJ_K_JIAL) ? `CIJ_LINK_REG
               : (accept && instr_valid && kind == CIJ_K_BAR) ? rt_f : rs_f;
      // The load destination is kept until the byte returns.
      if (accept && instr_valid && kind == CIJ_K_LDB)
        load_rt_q <= rs_f;
      wb_data <= load_valid ? {{(W-8){load_byte[7]}}, load_byte} : link;
      load_req  <= accept && instr_valid && kind == CIJ_K_LDB;
      load_addr <= idx_tgt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  redir_next_a: assert property (@(posedge clk) disable iff (!resetn)
    fire_now |=> redirect && redirect_pc == $past(pc_tgt))
    else $error("Jump did not redirect next cycle.");
  link31_a: assert property (@(posedge clk) disable iff (!resetn)
    (accept && instr_valid && kind == CIJ_K_JIAL && !load_valid)
    |=> wb_en && wb_reg == 5'h1F && wb_data == $past(instr_pc) + 4)
    else $error("Link write wrong.");
  squash_a: assert property (@(posedge clk) disable iff (!resetn)
    (accept && is_jump) |=> squash)
    else $error("Successor not squashed.");
  mode_a: assert property (@(posedge clk) disable iff (!resetn)
    (fire_now && !sole_compressed_set_flag) |=> !redirect_pc[0]
    && instruction_set_mode_bit == $past(tgt[0]))
    else $error("Mode bit not taken from target.");
  sequence drain_s;
    (state_q == CIJ_DRAIN) ##1 (state_q == CIJ_GO);
  endsequence
  barrier_a: assert property (@(posedge clk) disable iff (!resetn)
    drain_s |=> redirect && clear_instr_hazard)
    else $error("Barrier redirect missing.");
  nofetch_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CIJ_DRAIN && hazards_pending) |=> !redirect)
    else $error("Target fetched before hazards cleared.");
  ehb_a: assert property (@(posedge clk) disable iff (!resetn)
    clear_instr_hazard |-> $past(state_q) == CIJ_GO)
    else $error("Instruction hazard cleared wrongly.");
  zero_a: assert property (@(posedge clk) disable iff (!resetn)
    (accept && instr_valid && kind == CIJ_K_BAR && rt_f == 5'h00 && !load_valid) |=> !wb_en)
    else $error("Register zero written.");
  fault_a: assert property (@(posedge clk) disable iff (!resetn)
    (fire_now && !sole_compressed_set_flag && tgt[1:0] == 2'b10) |=> target_fault)
    else $error("Misaligned target not faulted.");
endmodule

// file: logic/cij_cfg.svh
`ifndef CIJ_CFG_SVH
`define CIJ_CFG_SVH
`define CIJ_OP_GROUP_A   6'h28
`define CIJ_OP_GROUP_B   6'h20
`define CIJ_SUB_INDEXED  5'h00
`define CIJ_LINK_REG     5'h1F
`define CIJ_LINK_INC     4
`define CIJ_BAR_MINOR    10'h07C
`define CIJ_POOL_MAJOR   6'h00
`define CIJ_POOL_MINOR   6'h3C
`define CIJ_EHB_WORD     32'h00001800
`define CIJ_MIN_RELEASE  6
`endif

// file: logic/cij_pkg.sv
package cij_pkg;
  typedef enum logic [1:0] {
    CIJ_IDLE  = 2'b00,
    CIJ_DRAIN = 2'b01,
    CIJ_GO    = 2'b10
  } cij_state_t;
  typedef enum logic [2:0] {
    CIJ_K_NONE = 3'b000,
    CIJ_K_JIC  = 3'b001,
    CIJ_K_JIAL = 3'b010,
    CIJ_K_BAR  = 3'b011,
    CIJ_K_EHB  = 3'b100,
    CIJ_K_LDB  = 3'b101
  } cij_kind_t;
endpackage

// file: test/cij_fetch_model.sv
module cij_fetch_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        squash,
  input  wire logic        load_req,
  input  wire logic [63:0] load_addr,
  output logic             hazards_pending,
  output logic             load_valid,
  output logic [7:0]       load_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q;
  logic       slow_q;
  logic       sq_q;
  // hazard drain window opens on a new squash.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 3'h0;
      slow_q <= 1'b0;
      sq_q <= 1'b0;
      load_valid <= 1'b0;
      load_byte <= 8'h00;
    end else begin
      sq_q <= squash;
      if (squash && !sq_q) begin
        cnt_q <= slow_q ? 3'h5 : 3'h1;
        slow_q <= !slow_q;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
      load_valid <= load_req;
      load_byte <= load_req ? (load_addr[7:0] ^ 8'hA5) : ~load_byte;
    end
  end
  assign hazards_pending = (squash && !sq_q) || (cnt_q != 3'h0);
endmodule

// file: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, instr_valid = 0, flag = 0, hz, lv;
  logic [31:0] instr = 0;
  logic [63:0] ipc = 0, ra = 0, rb = 0, s = 64'd35214, mode_e = 1;
  logic [7:0] lb;
  logic redirect, mode, squash, stall, fault, ceh, cih, wb_en, load_req;
  logic [4:0] wb_reg;
  logic [63:0] rpc, wb_data, load_addr;
  logic [66:0] rq[$];
  logic [66:0] e;
  logic [63:0] r, p;
  logic [68:0] wq[$];
  logic [63:0] lq[$];
  int bad_count = 0, check_count = 0, nce = 0, nci = 0, i;
  cij_unit dut_u (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
    .instr_pc(ipc), .reg_a(ra), .reg_b(rb), .sole_compressed_set_flag(flag),
    .hazards_pending(hz), .load_valid(lv), .load_byte(lb), .redirect(redirect),
    .redirect_pc(rpc), .instruction_set_mode_bit(mode), .squash(squash), .stall(stall),
    .target_fault(fault), .clear_exec_hazard(ceh), .clear_instr_hazard(cih), .wb_en(wb_en),
    .wb_reg(wb_reg), .wb_data(wb_data), .load_req(load_req), .load_addr(load_addr));
  cij_fetch_model fm_u (.clk(clk), .resetn(resetn), .squash(squash), .load_req(load_req),
    .load_addr(load_addr), .hazards_pending(hz), .load_valid(lv), .load_byte(lb));
  always #12.5 clk = ~clk;
  function automatic logic [63:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 7);
    s = s ^ (s << 17);
    return s;
  endfunction
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic put(input logic [31:0] w, input logic f, input logic [63:0] t, input logic sq,
    input logic [63:0] a, input logic [63:0] b, input logic [63:0] c);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= w;
    flag <= f;
    ra <= a;
    rb <= b;
    ipc <= c;
    if (!f) mode_e = t[0];
    rq.push_back({sq, !f && !t[0] && t[1], mode_e[0], f ? t : {t[63:1], 1'b0}});
  endtask
  task automatic jump(input logic link);
    logic [15:0] off;
    logic [63:0] pc, v;
    off = rnd();
    pc = rnd() & ~64'h1;
    v = rnd();
    if (link) wq.push_back({1'b1, 5'h1F, pc + 64'h4});
    put({link ? 6'h28 : 6'h20, 5'h00, 5'h03, off}, v[5], v + {{48{off[15]}}, off}, 1'b1, v, rb, pc);
  endtask
  always @(posedge clk) if (resetn) begin
    if (redirect) begin
      e = rq.pop_front();
      chk({fault, mode, rpc, squash | !e[66]}, {e[65:0], 1'b1});
      if (!e[66]) chk(hz, 0);
    end
    if (wb_en && wb_reg != 0) chk({wb_reg, wb_data}, wq.pop_front());
    if (load_req) chk(load_addr, lq.pop_front());
    nce += ceh;
    nci += cih;
  end
  initial begin
    #(25ns * 8000);
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 60; i++) jump(s[9]);
    for (i = 0; i < 6; i++) begin
      r = rnd();
      p = rnd() & ~64'h3;
      if (i % 3 != 0) wq.push_back({1'b1, i[0] ? 5'h1F : 5'h07, p + 64'h4});
      put({6'h00, 5'h04, i % 3 == 0 ? 5'h00 : i[0] ? 5'h1F : 5'h07, 10'h07C, 6'h3C}, i[1], r, 0,
          ra, r, p);
      @(posedge clk);
      instr_valid <= 1'b0;
      for (int k = 0; k < 40 && !redirect; k++) @(posedge clk);
      repeat (2) @(posedge clk);
    end
    chk(nci, 6);
    put(32'h00001800, 0, 0, 0, ra, rb, ipc);
    rq.pop_back();
    r = rnd();
    lq.push_back(r + 64'hFFFFFFFFFFFFFF80);
    wq.push_back({1'b1, 5'h09, {56{lq[0][7] ^ 1'b1}}, lq[0][7:0] ^ 8'hA5});
    put({6'h07, 5'h09, 5'h02, 16'hFF80}, 0, 0, 0, r, rb, ipc);
    rq.pop_back();
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (8) @(posedge clk);
    chk({nce, nci}, {32'd7, 32'd6});
    chk({rq.size(), wq.size(), lq.size()}, 0);
    wrap_up();
  end
endmodule
